// ---- include/fspc_defs.vh ----
// Constants for the flash self-programming controller.
// Included by the controller, not by its timer; definitions only.
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH

// Register map (byte addresses on the plain register port)
`define FSPC_ADDR_CSR        8'h68
`define FSPC_ADDR_PTR_LO     8'h6a
`define FSPC_ADDR_PTR_HI     8'h6b
`define FSPC_ADDR_PTR_EXT    8'h6c
`define FSPC_CSR_RESET       8'h00

// Control register fields
`define FSPC_BIT_IRQ_EN      7
`define FSPC_BIT_BUSY        6
`define FSPC_BIT_REEN        4
`define FSPC_BIT_LOCK        3
`define FSPC_BIT_PGWR        2
`define FSPC_BIT_PGER        1
`define FSPC_BIT_CMDEN       0

// Accepted low-five patterns
`define FSPC_PAT_REEN        5'h11
`define FSPC_PAT_LOCK        5'h09
`define FSPC_PAT_PGWR        5'h05
`define FSPC_PAT_PGER        5'h03
`define FSPC_PAT_FILL        5'h01

// Region and boot limits (word addresses)
`define FSPC_STALL_BASE      16'hf000
`define FSPC_BOOT_BASE_11    16'hfe00
`define FSPC_BOOT_BASE_10    16'hfc00
`define FSPC_BOOT_BASE_01    16'hf800
`define FSPC_BOOT_BASE_00    16'hf000

// Configuration read selectors
`define FSPC_SEL_FUSE_LO     16'h0000
`define FSPC_SEL_FUSE_EXT    16'h0002
`define FSPC_SEL_FUSE_HI     16'h0003

// Windows in core cycles
`define FSPC_STORE_WIN       3'd4
`define FSPC_LOAD_WIN        3'd3

// Programming time
`define FSPC_CLK_MHZ         20
`define FSPC_PROG_MIN_US     3700
`define FSPC_PROG_MAX_US     4500
`define FSPC_PROG_CYCLES     (`FSPC_PROG_MIN_US * `FSPC_CLK_MHZ)

`endif

// ---- verilog/fspc_prog_timer.v ----
// Programming timer: counts one erase/write/lock operation.
// Assumes start is a one-cycle pulse while not busy.
`timescale 1ns/1ps
`default_nettype none
module fspc_prog_timer #(
	parameter CYCLES = 74000,
	parameter W      = 17
) (
	// Clock and reset
	input  wire         core_clk,
	input  wire         reset,
	// Control
	input  wire         start,
	output wire         busy,
	output reg          done_q
);
	reg [W-1:0] cnt_q;

	assign busy = (cnt_q != {W{1'b0}});

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_q  <= {W{1'b0}};
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				cnt_q <= CYCLES[W-1:0];
			end else if (busy) begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				if (cnt_q == {{(W-1){1'b0}}, 1'b1})
					done_q <= 1'b1;
			end
		end
	end
endmodule // fspc_prog_timer
`default_nettype wire

// ---- verilog/fspc_ctrl.v ----
// Flash self-programming controller: control/status register, command
// windows, page buffer, boot/region decode and flash operation sequencing.
// Assumes the core gives one-cycle store/load strobes and honours stall.
//
// Operation
// [RULE_01] Boot area size from two-bit setting: 512/1024/2048/4096 words at top.
// [RULE_02] Words 0000-EFFF read-while-write region, F000-FFFF stall region.
// [RULE_03] Page from pointer bits 16:8; pointer bits 7:1 pick word of 128.
// [RULE_04] Software keeps word-select bits zero for page write.
// [RULE_05] Pointer bit 16 comes from the extension register.
// [RULE_06] Ready interrupt while enable, global enable and command enable clear.
// [RULE_07] Erase/write to concurrent region sets busy and blocks its reads.
// [RULE_08] Busy clears on re-enable after operation, or on buffer load start.
// [RULE_09] Re-enable plus store within four cycles restores reads, not when busy.
// [RULE_10] Re-enable during buffer loading discards the buffered data.
// [RULE_11] Lock-set plus store programs boot lock bits from data low byte.
// [RULE_12] Load within three cycles of lock-set reads lock or fuse bits.
// [RULE_13] Page-write plus store writes buffer to pointer page.
// [RULE_14] Page-erase plus store erases pointer page.
// [RULE_15] Core stalls during erase/write to the stall region; code stalls only in ST_PROG with read_region_busy_q clear.
// [RULE_16] Command enable alone: store puts data word in buffer slot.
// [RULE_17] Command enable window of four cycles; held during erase/write.
// [RULE_18] Only patterns 10001,01001,00101,00011,00001 take effect.
// [RULE_19] Erase, write or lock write lasts 3.7 to 4.5 ms.
// [RULE_20] Pointer 0000 low fuse, 0003 high fuse, 0002 extended fuse; code gives lock bits for 0000/0002, low fuse for 0001.
// [RULE_21] Programmed bits read zero, unprogrammed read one.
// [RULE_22] Store with no open window changes nothing.
// [RULE_23] Each command rewrite restarts the four-cycle window.
//
// The strobed register port is this design's own decision.
`include "fspc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl #(
	parameter PROG_CYCLES = `FSPC_PROG_CYCLES,
	parameter PAGE_WORDS  = 128,
	parameter FUSE_LO     = 8'hff,
	parameter FUSE_HI     = 8'hff,
	parameter FUSE_EXT    = 8'hff
) (
	// Clock and reset
	input  wire         core_clk,
	input  wire         reset,
	// Register port
	input  wire [7:0]   reg_addr,
	input  wire [7:0]   reg_wdata,
	input  wire         reg_wr,
	input  wire         reg_rd,
	output reg  [7:0]   reg_rdata_q,
	// Core program-memory instructions
	input  wire         store_req,
	input  wire         load_req,
	input  wire [15:0]  store_data,
	input  wire         global_irq_en,
	output reg  [7:0]   load_data_q,
	output reg          load_hit_q,
	output wire         core_stall,
	output wire         ready_irq,
	// Configuration and region status
	input  wire         boot_size_sel_hi,
	input  wire         boot_size_sel_lo,
	input  wire [15:0]  fetch_addr,
	output wire         fetch_in_boot,
	output wire         concurrent_read_block,
	// Flash array side
	output reg          flash_erase_q,
	output reg          flash_write_q,
	output reg  [8:0]   flash_page_q,
	output reg  [15:0]  flash_wdata_q,
	output reg  [6:0]   flash_widx_q,
	output reg          flash_wvalid_q,
	output reg  [7:0]   lock_bits_q
);
	localparam ST_IDLE = 2'd0;
	localparam ST_PROG = 2'd1;
	localparam ST_DUMP = 2'd2;

	reg  [7:0]  ptr_lo_q;
	reg  [7:0]  ptr_hi_q;
	reg         pointer_extension_reg_q;
	reg         ready_irq_enable_q;
	reg         read_region_busy_q;
	reg  [4:0]  cmd_q;
	reg  [2:0]  win_q;
	reg  [1:0]  state_q;
	reg         op_is_lock_q;
	reg         loading_q;
	reg  [15:0] buf_q [0:PAGE_WORDS-1];
	reg  [PAGE_WORDS-1:0] buf_vld_q;
	reg  [6:0]  dump_idx_q;
	reg  [15:0] boot_base;
	reg         tmr_start;

	wire [16:0] pointer = {pointer_extension_reg_q, ptr_hi_q, ptr_lo_q};
	wire [8:0]  page_select_field = pointer[16:8];       // see [RULE_03] [RULE_05]
	wire [6:0]  word_select_field = pointer[7:1];        // see [RULE_03]
	wire        tmr_busy;
	wire        tmr_done;
	wire        command_enable = cmd_q[`FSPC_BIT_CMDEN];
	wire        win_open = command_enable && (state_q == ST_IDLE);
	wire        csr_wr = reg_wr && (reg_addr == `FSPC_ADDR_CSR);
	wire [4:0]  pat = reg_wdata[4:0];
	wire        pat_ok = (pat == `FSPC_PAT_REEN) || (pat == `FSPC_PAT_LOCK) ||
		(pat == `FSPC_PAT_PGWR) || (pat == `FSPC_PAT_PGER) ||
		(pat == `FSPC_PAT_FILL);                         // see [RULE_18]
	wire        do_store = store_req && win_open;        // see [RULE_22]
	wire [15:0] page_word = {page_select_field[8:0], 7'h00};
	wire        tgt_stall = (page_word >= `FSPC_STALL_BASE); // see [RULE_02]

	// Boot area start from the size setting
	always @* begin
		case ({boot_size_sel_hi, boot_size_sel_lo})  // see [RULE_01]
		2'b11: boot_base = `FSPC_BOOT_BASE_11;
		2'b10: boot_base = `FSPC_BOOT_BASE_10;
		2'b01: boot_base = `FSPC_BOOT_BASE_01;
		default: boot_base = `FSPC_BOOT_BASE_00;
		endcase
	end
	assign fetch_in_boot = (fetch_addr >= boot_base);

	// Reads below the stall base are blocked while busy
	assign concurrent_read_block = read_region_busy_q &&
		(fetch_addr < `FSPC_STALL_BASE);                 // see [RULE_07]
	assign core_stall = (state_q == ST_PROG) && !op_is_lock_q &&
		!read_region_busy_q;                             // see [RULE_15]
	assign ready_irq = ready_irq_enable_q && global_irq_en &&
		!command_enable;                                 // see [RULE_06]

	always @* begin
		tmr_start = do_store && (cmd_q[`FSPC_BIT_PGWR] ||
			cmd_q[`FSPC_BIT_PGER] || cmd_q[`FSPC_BIT_LOCK]);
	end

	fspc_prog_timer #(
		.CYCLES (PROG_CYCLES),
		.W      (17)
	) u_timer (
		.core_clk (core_clk),
		.reset    (reset),
		.start    (tmr_start),
		.busy     (tmr_busy),
		.done_q   (tmr_done)
	);

	// Control register, window and sequencing
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ptr_lo_q                <= 8'h00;
			ptr_hi_q                <= 8'h00;
			pointer_extension_reg_q <= 1'b0;
			ready_irq_enable_q      <= 1'b0;
			read_region_busy_q      <= 1'b0;
			cmd_q                   <= 5'h00;
			win_q                   <= 3'd0;
			state_q                 <= ST_IDLE;
			op_is_lock_q            <= 1'b0;
			loading_q               <= 1'b0;
			buf_vld_q               <= {PAGE_WORDS{1'b0}};
			dump_idx_q              <= 7'h00;
			flash_erase_q           <= 1'b0;
			flash_write_q           <= 1'b0;
			flash_page_q            <= 9'h000;
			flash_wdata_q           <= 16'h0000;
			flash_widx_q            <= 7'h00;
			flash_wvalid_q          <= 1'b0;
			lock_bits_q             <= 8'hff;
		end else begin
			flash_erase_q  <= 1'b0;
			flash_write_q  <= 1'b0;
			flash_wvalid_q <= 1'b0;
			if (reg_wr && reg_addr == `FSPC_ADDR_PTR_LO)
				ptr_lo_q <= reg_wdata;
			if (reg_wr && reg_addr == `FSPC_ADDR_PTR_HI)
				ptr_hi_q <= reg_wdata;
			if (reg_wr && reg_addr == `FSPC_ADDR_PTR_EXT)
				pointer_extension_reg_q <= reg_wdata[0];
			if (csr_wr)
				ready_irq_enable_q <= reg_wdata[`FSPC_BIT_IRQ_EN];
			case (state_q)
			ST_IDLE: begin
				if (csr_wr && pat_ok) begin
					cmd_q <= pat;
					win_q <= `FSPC_STORE_WIN;            // see [RULE_23]
					if (pat == `FSPC_PAT_REEN && loading_q) begin
						buf_vld_q <= {PAGE_WORDS{1'b0}}; // see [RULE_10]
						loading_q <= 1'b0;
					end
				end else if (do_store) begin
					win_q <= 3'd0;
					if (cmd_q[`FSPC_BIT_REEN]) begin
						read_region_busy_q <= 1'b0;      // see [RULE_08] [RULE_09]
						cmd_q <= 5'h00;
					end else if (cmd_q[`FSPC_BIT_LOCK]) begin
						lock_bits_q  <= {2'b11, store_data[5:0]}; // see [RULE_11]
						op_is_lock_q <= 1'b1;
						state_q      <= ST_PROG;
					end else if (cmd_q[`FSPC_BIT_PGWR] ||
						cmd_q[`FSPC_BIT_PGER]) begin
						flash_page_q <= page_select_field;       // see [RULE_13] [RULE_14]
						op_is_lock_q <= 1'b0;
						state_q      <= ST_PROG;
						if (!tgt_stall)
							read_region_busy_q <= 1'b1;  // see [RULE_07]
					end else begin
						buf_vld_q[word_select_field] <= 1'b1; // see [RULE_16]
						loading_q          <= 1'b1;
						read_region_busy_q <= 1'b0;      // see [RULE_08]
						cmd_q              <= 5'h00;
					end
				end else if (win_q != 3'd0) begin
					win_q <= win_q - 3'd1;
					if (win_q == 3'd1)
						cmd_q <= 5'h00;                  // see [RULE_17]
				end
			end
			ST_PROG: begin
				if (tmr_done) begin                      // see [RULE_19]
					if (cmd_q[`FSPC_BIT_PGER]) begin
						flash_erase_q <= 1'b1;           // see [RULE_14]
						cmd_q   <= 5'h00;
						state_q <= ST_IDLE;
					end else if (cmd_q[`FSPC_BIT_PGWR]) begin
						dump_idx_q <= 7'h00;             // see [RULE_13]
						state_q    <= ST_DUMP;
					end else begin
						cmd_q   <= 5'h00;                // see [RULE_11]
						state_q <= ST_IDLE;
					end
				end
			end
			ST_DUMP: begin
				flash_widx_q   <= dump_idx_q;
				flash_wdata_q  <= buf_vld_q[dump_idx_q] ?
					buf_q[dump_idx_q] : 16'hffff;
				flash_wvalid_q <= 1'b1;
				dump_idx_q     <= dump_idx_q + 7'h01;
				if (dump_idx_q == 7'h7f) begin
					flash_write_q <= 1'b1;
					buf_vld_q     <= {PAGE_WORDS{1'b0}};
					loading_q     <= 1'b0;
					cmd_q         <= 5'h00;              // see [RULE_17]
					state_q       <= ST_IDLE;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Page buffer storage, no reset needed for data
	always @(posedge core_clk) begin
		if (state_q == ST_IDLE && !csr_wr && do_store &&
			cmd_q == `FSPC_PAT_FILL)
			buf_q[word_select_field] <= store_data;      // see [RULE_16]
	end

	// Load path for lock and fuse readback
	wire lock_win = command_enable && cmd_q[`FSPC_BIT_LOCK] &&
		(state_q == ST_IDLE) && (win_q > (`FSPC_STORE_WIN - `FSPC_LOAD_WIN));
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			load_data_q <= 8'h00;
			load_hit_q  <= 1'b0;
		end else begin
			load_hit_q <= load_req && lock_win;          // see [RULE_12]
			if (load_req && lock_win) begin
				if (!pointer[0])
					load_data_q <= lock_bits_q;          // see [RULE_21]
				else if (pointer[15:0] == `FSPC_SEL_FUSE_HI)
					load_data_q <= FUSE_HI;              // see [RULE_20]
				else if (pointer[15:0] == `FSPC_SEL_FUSE_EXT)
					load_data_q <= FUSE_EXT;
				else
					load_data_q <= FUSE_LO;
			end
		end
	end

	// Register read data, one cycle after the strobe
	always @(posedge core_clk or posedge reset) begin
		if (reset)
			reg_rdata_q <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
			`FSPC_ADDR_CSR: reg_rdata_q <= {ready_irq_enable_q,
				read_region_busy_q, 1'b0, cmd_q};
			`FSPC_ADDR_PTR_LO:  reg_rdata_q <= ptr_lo_q;
			`FSPC_ADDR_PTR_HI:  reg_rdata_q <= ptr_hi_q;
			`FSPC_ADDR_PTR_EXT: reg_rdata_q <= {7'h00,
				pointer_extension_reg_q};
			default: reg_rdata_q <= 8'h00;
			endcase
		end else
			reg_rdata_q <= 8'h00;
	end
endmodule // fspc_ctrl
`default_nettype wire

// ---- bench/fspc_ctrl_sva.sv ----
// Port checker for the flash self-programming controller.
// Bound to fspc_ctrl; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_sva (
	// Clock and reset
	input wire        core_clk,
	input wire        reset,
	// Core side
	input wire        load_req,
	input wire        load_hit_q,
	input wire        global_irq_en,
	input wire        ready_irq,
	input wire        core_stall,
	// Region decode
	input wire        boot_size_sel_hi,
	input wire        boot_size_sel_lo,
	input wire [15:0] fetch_addr,
	input wire        fetch_in_boot,
	input wire        concurrent_read_block,
	// Flash side
	input wire        flash_erase_q,
	input wire        flash_write_q,
	input wire [6:0]  flash_widx_q,
	input wire        flash_wvalid_q,
	input wire [7:0]  lock_bits_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	wire [15:0] boot_base = boot_size_sel_hi ?
		(boot_size_sel_lo ? 16'hfe00 : 16'hfc00) :
		(boot_size_sel_lo ? 16'hf800 : 16'hf000);
	a_boot_decode: assert property (
		fetch_in_boot == (fetch_addr >= boot_base))
		else $error("boot area decode wrong");
	a_region_limit: assert property (
		concurrent_read_block |-> fetch_addr < 16'hf000)
		else $error("read block outside concurrent region");
	a_irq_gate: assert property (ready_irq |-> global_irq_en)
		else $error("ready request without global enable");
	a_load_reply: assert property (load_hit_q |-> $past(load_req))
		else $error("load answer without load");
	a_stall_span: assert property (
		$rose(core_stall) |-> core_stall [*8])
		else $error("stall dropped early");
	a_erase_pulse: assert property (flash_erase_q |=> !flash_erase_q)
		else $error("erase pulse too long");
	a_write_last: assert property (
		flash_write_q |-> flash_wvalid_q && flash_widx_q == 7'h7f)
		else $error("write pulse not with last word");
	a_dump_step: assert property (
		flash_wvalid_q && flash_widx_q != 7'h7f |=> flash_wvalid_q &&
		flash_widx_q == $past(flash_widx_q) + 7'h01)
		else $error("page dump out of order");
	a_lock_top: assert property (lock_bits_q[7:6] == 2'b11)
		else $error("unused lock bits not one");
	c_erase: cover property (flash_erase_q);
	c_write: cover property (flash_write_q);
	c_stall: cover property ($rose(core_stall));
	c_load: cover property (load_hit_q);
endmodule // fspc_ctrl_sva
bind fspc_ctrl fspc_ctrl_sva chk_u (.core_clk(core_clk), .reset(reset),
	.load_req(load_req), .load_hit_q(load_hit_q),
	.global_irq_en(global_irq_en), .ready_irq(ready_irq),
	.core_stall(core_stall), .boot_size_sel_hi(boot_size_sel_hi),
	.boot_size_sel_lo(boot_size_sel_lo), .fetch_addr(fetch_addr),
	.fetch_in_boot(fetch_in_boot),
	.concurrent_read_block(concurrent_read_block),
	.flash_erase_q(flash_erase_q), .flash_write_q(flash_write_q),
	.flash_widx_q(flash_widx_q), .flash_wvalid_q(flash_wvalid_q),
	.lock_bits_q(lock_bits_q));
`default_nettype wire

// ---- bench/fspc_core_model.sv ----
// Core model: issues one-cycle store and load instruction pulses.
// Called by the bench right after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module fspc_core_model (
	// Clock
	input wire          core_clk,
	// Instructions
	input wire          core_stall,
	output logic        store_req,
	output logic        load_req,
	output logic [15:0] store_data
);
	initial {store_req, load_req, store_data} = '0;
	task automatic store(input logic [15:0] d);
		while (core_stall) @(posedge core_clk);
		store_data <= d;
		store_req <= 1'b1;
		@(posedge core_clk);
		store_req <= 1'b0;
		// Released data must not look valid
		store_data <= ~d;
	endtask
	task automatic load();
		load_req <= 1'b1;
		@(posedge core_clk);
		load_req <= 1'b0;
	endtask
endmodule // fspc_core_model
`default_nettype wire

// ---- bench/fspc_ctrl_tb_top.sv ----
// Self-checking bench for the flash self-programming controller.
// Register port driven here; core side through fspc_core_model.
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_tb_top;
	localparam int PC = 20;
	logic        core_clk, reset, reg_wr, reg_rd, global_irq_en;
	logic        boot_size_sel_hi, boot_size_sel_lo;
	logic [7:0]  reg_addr, reg_wdata;
	logic [15:0] fetch_addr;
	wire  [7:0]  reg_rdata_q, load_data_q, lock_bits_q;
	wire         store_req, load_req, load_hit_q, core_stall, ready_irq;
	wire  [15:0] store_data, flash_wdata_q;
	wire         fetch_in_boot, concurrent_read_block, flash_erase_q;
	wire         flash_write_q, flash_wvalid_q;
	wire  [8:0]  flash_page_q;
	wire  [6:0]  flash_widx_q;
	logic [15:0] dump [0:127];
	logic [15:0] bases [4] = '{16'hf000, 16'hf800, 16'hfc00, 16'hfe00};
	int          err_total = 0, n_tests = 0, n_erase = 0, n;
	fspc_ctrl #(.PROG_CYCLES(PC), .FUSE_LO(8'ha5), .FUSE_HI(8'h5a),
		.FUSE_EXT(8'h3c)) dut_u (.core_clk(core_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .store_req(store_req),
		.load_req(load_req), .store_data(store_data),
		.global_irq_en(global_irq_en), .load_data_q(load_data_q),
		.load_hit_q(load_hit_q), .core_stall(core_stall),
		.ready_irq(ready_irq), .boot_size_sel_hi(boot_size_sel_hi),
		.boot_size_sel_lo(boot_size_sel_lo), .fetch_addr(fetch_addr),
		.fetch_in_boot(fetch_in_boot),
		.concurrent_read_block(concurrent_read_block),
		.flash_erase_q(flash_erase_q), .flash_write_q(flash_write_q),
		.flash_page_q(flash_page_q), .flash_wdata_q(flash_wdata_q),
		.flash_widx_q(flash_widx_q), .flash_wvalid_q(flash_wvalid_q),
		.lock_bits_q(lock_bits_q));
	fspc_core_model core_u (.core_clk(core_clk), .core_stall(core_stall),
		.store_req(store_req), .load_req(load_req),
		.store_data(store_data));
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (flash_wvalid_q) dump[flash_widx_q] <= flash_wdata_q;
		if (flash_erase_q) n_erase <= n_erase + 1;
	end
	task automatic chk(input string nm, input logic [15:0] e, s);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdc(input logic [7:0] a, e, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, e, reg_rdata_q);
		@(posedge core_clk);
	endtask
	task automatic fill(input logic [15:0] d);
		wr(8'h68, 8'h01);
		core_u.store(d);
	endtask
	task automatic wait_done(input logic wsel);
		n = 0;
		while ((wsel ? flash_write_q : flash_erase_q) !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			#1 n++;
		end
		@(posedge core_clk);
	endtask
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		finish_test;
	end
	initial begin
		{core_clk, reg_wr, reg_rd, reg_addr, reg_wdata, fetch_addr} = '0;
		{reset, global_irq_en, boot_size_sel_hi, boot_size_sel_lo} = 4'hf;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rdc(8'h68, 8'h00, "csr reset");
		rdc(8'h40, 8'h00, "unmapped");
		wr(8'h68, 8'h07);
		rdc(8'h68, 8'h00, "bad pattern");
		wr(8'h68, 8'h80);
		#1 chk("irq", 1, ready_irq);
		@(posedge core_clk);
		global_irq_en <= 1'b0;
		@(posedge core_clk);
		#1 chk("irq masked", 0, ready_irq);
		@(posedge core_clk);
		global_irq_en <= 1'b1;
		wr(8'h68, 8'h03);
		repeat (6) @(posedge core_clk);
		core_u.store(16'h0000);
		rdc(8'h68, 8'h00, "lapsed");
		chk("no erase", 0, n_erase);
		wr(8'h6b, 8'h01);
		wr(8'h68, 8'h83);
		core_u.store(16'h5555);
		#1 chk("rww block", 1, concurrent_read_block);
		chk("irq held", 0, ready_irq);
		@(posedge core_clk);
		rdc(8'h68, 8'hc3, "cmd held");
		wait_done(1'b0);
		chk("erase time", 1, n + 3 >= PC && n + 3 <= PC * 45 / 37 + 2);
		chk("erase page", 9'h001, flash_page_q);
		rdc(8'h68, 8'hc0, "busy kept");
		wr(8'h68, 8'h91);
		core_u.store(16'h0000);
		rdc(8'h68, 8'h80, "reenabled");
		wr(8'h6c, 8'h01);
		wr(8'h6b, 8'he0);
		wr(8'h68, 8'h03);
		core_u.store(16'h0000);
		#1 chk("stall", 1, core_stall);
		wait_done(1'b0);
		chk("stall page", 9'h1e0, flash_page_q);
		wr(8'h6c, 8'h00);
		wr(8'h6b, 8'h01);
		wr(8'h6a, 8'h07);
		fill(16'h1234);
		wr(8'h6a, 8'h00);
		wr(8'h68, 8'h05);
		core_u.store(16'h0000);
		wait_done(1'b1);
		chk("word 3", 16'h1234, dump[3]);
		chk("word 0", 16'hffff, dump[0]);
		chk("write page", 9'h001, flash_page_q);
		wr(8'h6a, 8'h0a);
		fill(16'hbeef);
		rdc(8'h68, 8'h00, "busy cleared");
		wr(8'h68, 8'h11);
		core_u.store(16'h0000);
		wr(8'h6a, 8'h00);
		wr(8'h68, 8'h05);
		core_u.store(16'h0000);
		wait_done(1'b1);
		chk("discarded", 16'hffff, dump[5]);
		wr(8'h68, 8'h09);
		core_u.store(16'hab33);
		repeat (40) @(posedge core_clk);
		chk("lock bits", 8'hf3, lock_bits_q);
		wr(8'h6b, 8'h00);
		wr(8'h6a, 8'h03);
		wr(8'h68, 8'h09);
		core_u.load();
		#1 chk("fuse high", 8'h5a, load_data_q);
		chk("load hit", 1, load_hit_q);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			{boot_size_sel_hi, boot_size_sel_lo} <= 2'(i);
			fetch_addr <= bases[i];
			@(posedge core_clk);
			#1 chk("boot base", 1, fetch_in_boot);
			@(posedge core_clk);
			fetch_addr <= bases[i] - 16'h0001;
			#1 chk("below boot", 0, fetch_in_boot);
		end
		finish_test;
	end
endmodule // fspc_ctrl_tb_top
`default_nettype wire
